// [include/bsob_pkg.sv]
package bsob_pkg;

  // Register indices on the plain port
  localparam logic [4:0] ADDR_CARRIER_REF   = 5'h01;
  localparam logic [4:0] ADDR_CARRIER_DRV   = 5'h02;
  localparam logic [4:0] ADDR_CARRIER_FIN   = 5'h03;
  localparam logic [4:0] ADDR_PEAKING_REF   = 5'h04;
  localparam logic [4:0] ADDR_PEAKING_DRV   = 5'h05;
  localparam logic [4:0] ADDR_PEAKING_FIN   = 5'h06;
  localparam logic [4:0] ADDR_STATUS        = 5'h08;
  localparam logic [4:0] ADDR_UNLOCK_KEY    = 5'h11;

  localparam logic [7:0] UNLOCK_PASSCODE    = 8'hE3;

  localparam int         REF_CODE_W         = 6;
  localparam logic [5:0] REF_CODE_MASK      = 6'h3F;

  // Factory codes (decimal 40 carrier, 34 peaking)
  localparam logic [5:0] FACTORY_CARRIER_REF = 6'h28;
  localparam logic [5:0] FACTORY_PEAKING_REF = 6'h22;
  localparam logic [7:0] FACTORY_GATE_OFFSET = 8'h80;
  // Used only when the one-time memory is blank
  localparam logic [5:0] BLANK_REF_CODE      = 6'h20;

  localparam int         STATUS_UNLOCK_BIT  = 0;
  localparam int         STATUS_TX_BIT      = 1;

  // Bias switching time limit, longest time rounds down
  localparam int CLOCK_MHZ        = 125;
  localparam int SWITCH_LIMIT_NS  = 100;
  localparam int SWITCH_LIMIT_CYC = (SWITCH_LIMIT_NS * CLOCK_MHZ) / 1000;

  typedef enum logic [0:0] {
    BSOB_LOAD,
    BSOB_RUN
  } bsob_phase_t;

endpackage : bsob_pkg

// [hdl/bsob_gate_drive.sv]
`timescale 1ns/1ps
// One bias group: shared ceiling, two offset codes, shut-off when transmit is off
module bsob_gate_drive (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       tx_on,
  input  wire logic [5:0] ref_code,
  input  wire logic [7:0] driver_offset,
  input  wire logic [7:0] final_offset,
  output logic      [5:0] ceiling_code,
  output logic      [7:0] driver_gate_level,
  output logic      [7:0] final_gate_level,
  output logic            gates_on
);

  typedef struct packed {
    logic [5:0] ceil;
    logic [7:0] drv;
    logic [7:0] fin;
    logic       on;
  } bsob_gd_state_t;

  bsob_gd_state_t st_q;
  bsob_gd_state_t st_d;

  // Offset 0 gives full ceiling; each step lowers the gate monotonically
  function automatic logic [7:0] gate_level(input logic [7:0] off);
    gate_level = 8'hFF - off; // RQ10
  endfunction : gate_level

  always_comb begin
    st_d      = st_q;
    st_d.ceil = ref_code;              // RQ11
    st_d.on   = tx_on;                 // RQ1
    if (tx_on) begin
      st_d.drv = gate_level(driver_offset); // RQ12
      st_d.fin = gate_level(final_offset);  // RQ12
    end else begin
      // Gates grounded regardless of codes
      st_d.drv = 8'h00;                // RQ2
      st_d.fin = 8'h00;                // RQ2
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ceiling_code      = st_q.ceil;
  assign driver_gate_level = st_q.drv;
  assign final_gate_level  = st_q.fin;
  assign gates_on          = st_q.on;

  a_gate_follow_tx: assert property (@(posedge clock) disable iff (reset) // RQ1
    $changed(tx_on) |=> (gates_on == $past(tx_on)))
    else $error("bias state did not follow transmit enable");

  a_gates_grounded: assert property (@(posedge clock) disable iff (reset) // RQ2
    !tx_on |=> (driver_gate_level == 8'h00 && final_gate_level == 8'h00))
    else $error("gate not grounded while transmit off");

  a_offset_order: assert property (@(posedge clock) disable iff (reset) // RQ10
    (tx_on && driver_offset == 8'h00) |=> driver_gate_level == 8'hFF)
    else $error("zero offset did not pass full ceiling");

  a_ceiling_shared: assert property (@(posedge clock) disable iff (reset) // RQ11
    1'b1 |=> ceiling_code == $past(ref_code))
    else $error("ceiling not taken from reference code");

endmodule : bsob_gate_drive

// [hdl/bsob_bank.sv]
`timescale 1ns/1ps
// Operation
// RQ1: Bias switches within 100 ns of enable.
// RQ2: Transmit off grounds every gate.
// RQ3: Reference code is 6 bits, top ignored.
// RQ4: Load from memory; writes need unlock.
// RQ5: Factory reference codes 40 and 34.
// RQ6: Passcode write to 17 enters unlock.
// RQ7: Unlocked writes update registers one to six.
// RQ8: Supply cycle reloads memory values.
// RQ9: Other value at 17 clears unlock.
// RQ10: Larger offset code lowers gate voltage.
// RQ11: Reference code sets both stage ceilings.
// RQ12: Each stage uses its own offset.
// RQ13: Bias applied without any host access.
// RQ14: Passcode is hexadecimal E3.
// RQ15: Bias registers always readable.
// RQ16: Locked writes dropped; unlock resets inactive.
module bsob_bank (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       otp_programmed,
  input  wire logic       tx_enable,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  output logic      [5:0] carrier_ceiling,
  output logic      [7:0] carrier_driver_gate,
  output logic      [7:0] carrier_final_gate,
  output logic            carrier_gates_on,
  output logic      [5:0] peaking_ceiling,
  output logic      [7:0] peaking_driver_gate,
  output logic      [7:0] peaking_final_gate,
  output logic            peaking_gates_on,
  output logic            override_unlock_state
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    bsob_pkg::bsob_phase_t phase;
    logic                  unlock;
    logic [5:0]            carrier_ref;
    logic [7:0]            carrier_driver_gate_offset;
    logic [7:0]            carrier_final_gate_offset;
    logic [5:0]            peaking_ref;
    logic [7:0]            peaking_driver_gate_offset;
    logic [7:0]            peaking_final_gate_offset;
    logic [7:0]            rdata;
  } bsob_bank_state_t;

  bsob_bank_state_t st_q;
  bsob_bank_state_t st_d;

  function automatic logic is_bias_addr(input logic [4:0] a);
    is_bias_addr = (a >= bsob_pkg::ADDR_CARRIER_REF) && (a <= bsob_pkg::ADDR_PEAKING_FIN);
  endfunction : is_bias_addr

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d       = st_q;
    st_d.rdata = 8'h00;
    unique case (st_q.phase)
      bsob_pkg::BSOB_LOAD: begin
        // Reset stands for a power cycle of the control supply
        if (otp_programmed) begin
          st_d.carrier_ref = bsob_pkg::FACTORY_CARRIER_REF; // RQ4 RQ5 RQ8
          st_d.peaking_ref = bsob_pkg::FACTORY_PEAKING_REF; // RQ5
        end else begin
          // Blank memory: safe defaults protect the transistors
          st_d.carrier_ref = bsob_pkg::BLANK_REF_CODE;
          st_d.peaking_ref = bsob_pkg::BLANK_REF_CODE;
        end
        st_d.carrier_driver_gate_offset = bsob_pkg::FACTORY_GATE_OFFSET; // RQ8
        st_d.carrier_final_gate_offset  = bsob_pkg::FACTORY_GATE_OFFSET;
        st_d.peaking_driver_gate_offset = bsob_pkg::FACTORY_GATE_OFFSET;
        st_d.peaking_final_gate_offset  = bsob_pkg::FACTORY_GATE_OFFSET;
        st_d.phase = bsob_pkg::BSOB_RUN; // RQ13
      end
      bsob_pkg::BSOB_RUN: begin
        if (reg_write && reg_addr == bsob_pkg::ADDR_UNLOCK_KEY) begin
          st_d.unlock = (reg_wdata == bsob_pkg::UNLOCK_PASSCODE); // RQ6 RQ9 RQ14
        end
        // Locked writes fall through and are dropped
        if (reg_write && st_q.unlock && is_bias_addr(reg_addr)) begin // RQ4 RQ7 RQ16
          unique case (reg_addr)
            bsob_pkg::ADDR_CARRIER_REF:
              st_d.carrier_ref = reg_wdata[bsob_pkg::REF_CODE_W-1:0]; // RQ3
            bsob_pkg::ADDR_CARRIER_DRV: st_d.carrier_driver_gate_offset = reg_wdata;
            bsob_pkg::ADDR_CARRIER_FIN: st_d.carrier_final_gate_offset  = reg_wdata;
            bsob_pkg::ADDR_PEAKING_REF:
              st_d.peaking_ref = reg_wdata[bsob_pkg::REF_CODE_W-1:0]; // RQ3
            bsob_pkg::ADDR_PEAKING_DRV: st_d.peaking_driver_gate_offset = reg_wdata;
            default:                    st_d.peaking_final_gate_offset  = reg_wdata;
          endcase
        end
      end
    endcase
    // Reads work in any phase and lock state
    if (reg_read) begin // RQ15
      case (reg_addr)
        bsob_pkg::ADDR_CARRIER_REF: st_d.rdata = {2'b00, st_q.carrier_ref};
        bsob_pkg::ADDR_CARRIER_DRV: st_d.rdata = st_q.carrier_driver_gate_offset;
        bsob_pkg::ADDR_CARRIER_FIN: st_d.rdata = st_q.carrier_final_gate_offset;
        bsob_pkg::ADDR_PEAKING_REF: st_d.rdata = {2'b00, st_q.peaking_ref};
        bsob_pkg::ADDR_PEAKING_DRV: st_d.rdata = st_q.peaking_driver_gate_offset;
        bsob_pkg::ADDR_PEAKING_FIN: st_d.rdata = st_q.peaking_final_gate_offset;
        bsob_pkg::ADDR_STATUS: begin
          st_d.rdata[bsob_pkg::STATUS_UNLOCK_BIT] = st_q.unlock;
          st_d.rdata[bsob_pkg::STATUS_TX_BIT]     = tx_enable;
        end
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= '0; // RQ16
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata             = st_q.rdata;
  assign override_unlock_state = st_q.unlock;

  ////////////////////////////////////////////////////////////////////////////
  // Gate drive, one instance per group

  bsob_gate_drive u_carrier (
    .clock             (clock),
    .reset             (reset),
    .tx_on             (tx_enable),
    .ref_code          (st_q.carrier_ref),
    .driver_offset     (st_q.carrier_driver_gate_offset),
    .final_offset      (st_q.carrier_final_gate_offset),
    .ceiling_code      (carrier_ceiling),
    .driver_gate_level (carrier_driver_gate),
    .final_gate_level  (carrier_final_gate),
    .gates_on          (carrier_gates_on)
  );

  bsob_gate_drive u_peaking (
    .clock             (clock),
    .reset             (reset),
    .tx_on             (tx_enable),
    .ref_code          (st_q.peaking_ref),
    .driver_offset     (st_q.peaking_driver_gate_offset),
    .final_offset      (st_q.peaking_final_gate_offset),
    .ceiling_code      (peaking_ceiling),
    .driver_gate_level (peaking_driver_gate),
    .final_gate_level  (peaking_final_gate),
    .gates_on          (peaking_gates_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Longest bias switching time in cycles; a local int so it can bound a delay range
  localparam int SWITCH_LIMIT = bsob_pkg::SWITCH_LIMIT_CYC;

  sequence s_key_right;
    reg_write && reg_addr == bsob_pkg::ADDR_UNLOCK_KEY
      && reg_wdata == bsob_pkg::UNLOCK_PASSCODE && st_q.phase == bsob_pkg::BSOB_RUN;
  endsequence

  sequence s_key_wrong;
    reg_write && reg_addr == bsob_pkg::ADDR_UNLOCK_KEY
      && reg_wdata != bsob_pkg::UNLOCK_PASSCODE && st_q.phase == bsob_pkg::BSOB_RUN;
  endsequence

  sequence s_locked_write;
    reg_write && !st_q.unlock && st_q.phase == bsob_pkg::BSOB_RUN;
  endsequence

  sequence s_open_write;
    reg_write && st_q.unlock && st_q.phase == bsob_pkg::BSOB_RUN;
  endsequence

  // Reset release stands for the control supply coming up
  sequence s_release;
    reset ##1 !reset;
  endsequence

  sequence s_tx_edge;
    $changed(tx_enable);
  endsequence

  a_unlock_enter: assert property (@(posedge clock) disable iff (reset) // RQ6
    s_key_right |=> override_unlock_state)
    else $error("passcode did not unlock");

  a_unlock_clear: assert property (@(posedge clock) disable iff (reset) // RQ9
    s_key_wrong |=> !override_unlock_state)
    else $error("wrong key did not clear unlock");

  a_unlock_hold: assert property (@(posedge clock) disable iff (reset) // RQ6
    !(reg_write && reg_addr == bsob_pkg::ADDR_UNLOCK_KEY) |=> $stable(override_unlock_state))
    else $error("unlock state changed without a key write");

  a_locked_drop: assert property (@(posedge clock) disable iff (reset) // RQ16
    s_locked_write |=> $stable(st_q.carrier_ref) && $stable(st_q.peaking_ref)
      && $stable(st_q.carrier_driver_gate_offset) && $stable(st_q.carrier_final_gate_offset)
      && $stable(st_q.peaking_driver_gate_offset) && $stable(st_q.peaking_final_gate_offset))
    else $error("locked write changed a register");

  a_unlocked_write: assert property (@(posedge clock) disable iff (reset) // RQ7
    s_open_write ##0 (reg_addr == bsob_pkg::ADDR_CARRIER_DRV)
      |=> st_q.carrier_driver_gate_offset == $past(reg_wdata))
    else $error("unlocked write not stored");

  a_unlocked_fin: assert property (@(posedge clock) disable iff (reset) // RQ7
    s_open_write ##0 (reg_addr == bsob_pkg::ADDR_CARRIER_FIN)
      |=> st_q.carrier_final_gate_offset == $past(reg_wdata))
    else $error("unlocked carrier final write not stored");

  a_unlocked_peak_drv: assert property (@(posedge clock) disable iff (reset) // RQ7
    s_open_write ##0 (reg_addr == bsob_pkg::ADDR_PEAKING_DRV)
      |=> st_q.peaking_driver_gate_offset == $past(reg_wdata))
    else $error("unlocked peaking driver write not stored");

  a_unlocked_peak_fin: assert property (@(posedge clock) disable iff (reset) // RQ7
    s_open_write ##0 (reg_addr == bsob_pkg::ADDR_PEAKING_FIN)
      |=> st_q.peaking_final_gate_offset == $past(reg_wdata))
    else $error("unlocked peaking final write not stored");

  a_unlocked_ref: assert property (@(posedge clock) disable iff (reset) // RQ3
    s_open_write ##0 (reg_addr == bsob_pkg::ADDR_PEAKING_REF)
      |=> st_q.peaking_ref == $past(reg_wdata[bsob_pkg::REF_CODE_W-1:0]))
    else $error("reference write not cut to its low bits");

  a_ref_width: assert property (@(posedge clock) disable iff (reset) // RQ3
    (reg_read && reg_addr == bsob_pkg::ADDR_CARRIER_REF) |=> reg_rdata[7:6] == 2'b00)
    else $error("reference code upper bits not zero");

  a_factory_load: assert property (@(posedge clock) // RQ5
    s_release ##0 otp_programmed |=> st_q.carrier_ref == bsob_pkg::FACTORY_CARRIER_REF
      && st_q.peaking_ref == bsob_pkg::FACTORY_PEAKING_REF)
    else $error("factory codes not loaded");

  a_blank_load: assert property (@(posedge clock) // RQ4
    s_release ##0 !otp_programmed |=> st_q.carrier_ref == bsob_pkg::BLANK_REF_CODE
      && st_q.peaking_ref == bsob_pkg::BLANK_REF_CODE)
    else $error("blank memory codes not loaded");

  a_offset_reload: assert property (@(posedge clock) // RQ8
    s_release |=> st_q.carrier_driver_gate_offset == bsob_pkg::FACTORY_GATE_OFFSET
      && st_q.carrier_final_gate_offset == bsob_pkg::FACTORY_GATE_OFFSET
      && st_q.peaking_driver_gate_offset == bsob_pkg::FACTORY_GATE_OFFSET
      && st_q.peaking_final_gate_offset == bsob_pkg::FACTORY_GATE_OFFSET)
    else $error("gate offsets not reloaded");

  a_unlock_reset: assert property (@(posedge clock) // RQ16
    reset |=> !override_unlock_state)
    else $error("unlock state survived reset");

  a_load_once: assert property (@(posedge clock) disable iff (reset) // RQ13
    st_q.phase == bsob_pkg::BSOB_LOAD |=> st_q.phase == bsob_pkg::BSOB_RUN)
    else $error("load phase did not end");

  a_read_any: assert property (@(posedge clock) disable iff (reset) // RQ15
    (reg_read && reg_addr == bsob_pkg::ADDR_PEAKING_FIN)
      |=> reg_rdata == $past(st_q.peaking_final_gate_offset))
    else $error("read returned wrong value");

  a_read_ref: assert property (@(posedge clock) disable iff (reset) // RQ15
    (reg_read && reg_addr == bsob_pkg::ADDR_CARRIER_REF)
      |=> reg_rdata == {2'b00, $past(st_q.carrier_ref)})
    else $error("reference read returned wrong value");

  a_read_idle: assert property (@(posedge clock) disable iff (reset) // RQ15
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data stood beyond its cycle");

  a_status_read: assert property (@(posedge clock) disable iff (reset) // RQ15
    (reg_read && reg_addr == bsob_pkg::ADDR_STATUS)
      |=> reg_rdata[bsob_pkg::STATUS_UNLOCK_BIT] == $past(st_q.unlock)
      && reg_rdata[bsob_pkg::STATUS_TX_BIT] == $past(tx_enable))
    else $error("status read wrong");

  a_key_write_only: assert property (@(posedge clock) disable iff (reset) // RQ14
    (reg_read && reg_addr == bsob_pkg::ADDR_UNLOCK_KEY) |=> reg_rdata == 8'h00)
    else $error("unlock key register readable");

  a_switch_fast: assert property (@(posedge clock) disable iff (reset) // RQ1
    s_tx_edge |-> ##[1:SWITCH_LIMIT] (carrier_gates_on == tx_enable
      && peaking_gates_on == tx_enable))
    else $error("bias did not switch in time");

  a_gates_off: assert property (@(posedge clock) disable iff (reset) // RQ2
    !tx_enable |=> carrier_driver_gate == 8'h00 && carrier_final_gate == 8'h00
      && peaking_driver_gate == 8'h00 && peaking_final_gate == 8'h00)
    else $error("a gate was not grounded while transmit off");

  a_ceiling_follow: assert property (@(posedge clock) disable iff (reset) // RQ11
    1'b1 |=> carrier_ceiling == $past(st_q.carrier_ref)
      && peaking_ceiling == $past(st_q.peaking_ref))
    else $error("ceiling did not follow its reference code");

endmodule : bsob_bank

// [testbench/bsob_host_model.sv]
`timescale 1ns/1ps
// Host side of the plain register port; one strobe per call, no wait states
module bsob_host_model (
  input  wire logic       clock,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_write,
  output logic            reg_read,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 5'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Idle data must not look like a held value
    reg_wdata <= ~d;
    #1;
  endtask : write_reg

  task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : read_reg

  task automatic unlock;
    write_reg(5'h11, bsob_pkg::UNLOCK_PASSCODE);
  endtask : unlock
endmodule : bsob_host_model

// [testbench/bias_setting_override_bank_test.sv]
`timescale 1ns/1ps
module bias_setting_override_bank_test;
  logic       clock;
  logic       reset;
  logic       otp_programmed;
  logic       tx_enable;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_write;
  logic       reg_read;
  logic [7:0] reg_rdata;
  logic [5:0] c_ceil;
  logic [5:0] p_ceil;
  logic [7:0] c_drv;
  logic [7:0] c_fin;
  logic [7:0] p_drv;
  logic [7:0] p_fin;
  logic       c_on;
  logic       p_on;
  logic       unl;
  logic [7:0] rd;
  int         mismatches = 0;
  int         check_count = 0;

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  bsob_bank u_dut (.clock(clock), .reset(reset), .otp_programmed(otp_programmed),
    .tx_enable(tx_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .carrier_ceiling(c_ceil), .carrier_driver_gate(c_drv), .carrier_final_gate(c_fin),
    .carrier_gates_on(c_on), .peaking_ceiling(p_ceil), .peaking_driver_gate(p_drv),
    .peaking_final_gate(p_fin), .peaking_gates_on(p_on), .override_unlock_state(unl));

  bsob_host_model u_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk8

  task automatic chk1(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    u_host.read_reg(a, rd);
    chk8("reg_rdata", e, rd);
  endtask : rd_chk

  // Reset stands for a cycle of the control supply
  task automatic do_reset(input logic otp);
    @(posedge clock);
    reset          <= 1'b1;
    otp_programmed <= otp;
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : do_reset

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #40000;
    mismatches++;
    $display("ERROR watchdog expected end seen hang");
    report_and_stop();
  end

  initial begin
    reset          = 1'b1;
    otp_programmed = 1'b1;
    tx_enable      = 1'b1;
    do_reset(1'b1);
    rd_chk(5'h01, 8'h28);
    rd_chk(5'h02, 8'h80);
    rd_chk(5'h04, 8'h22);
    rd_chk(5'h09, 8'h00);
    chk8("carrier_ceiling", 8'h28, {2'b00, c_ceil});
    chk8("carrier_driver_gate", 8'h7F, c_drv);
    $display("test factory_load done");
    u_host.write_reg(5'h02, 8'h10);
    rd_chk(5'h02, 8'h80);
    chk1("override_unlock_state", 1'b0, unl);
    $display("test locked_write done");
    u_host.unlock();
    chk1("override_unlock_state", 1'b1, unl);
    rd_chk(5'h08, 8'h03);
    rd_chk(5'h11, 8'h00);
    u_host.write_reg(5'h01, 8'hFF);
    u_host.write_reg(5'h02, 8'h00);
    u_host.write_reg(5'h03, 8'h10);
    u_host.write_reg(5'h04, 8'h15);
    u_host.write_reg(5'h05, 8'h20);
    u_host.write_reg(5'h06, 8'hFF);
    rd_chk(5'h01, 8'h3F);
    rd_chk(5'h05, 8'h20);
    chk8("carrier_ceiling", 8'h3F, {2'b00, c_ceil});
    chk8("carrier_driver_gate", 8'hFF, c_drv);
    chk8("carrier_final_gate", 8'hEF, c_fin);
    chk8("peaking_ceiling", 8'h15, {2'b00, p_ceil});
    chk8("peaking_driver_gate", 8'hDF, p_drv);
    chk8("peaking_final_gate", 8'h00, p_fin);
    $display("test unlocked_write done");
    u_host.write_reg(5'h11, 8'hE2);
    chk1("override_unlock_state", 1'b0, unl);
    u_host.write_reg(5'h05, 8'h00);
    rd_chk(5'h05, 8'h20);
    $display("test relock done");
    @(posedge clock);
    tx_enable <= 1'b0;
    @(posedge clock);
    #1;
    chk8("carrier_driver_gate", 8'h00, c_drv);
    chk8("peaking_driver_gate", 8'h00, p_drv);
    chk1("carrier_gates_on", 1'b0, c_on);
    chk1("peaking_gates_on", 1'b0, p_on);
    chk8("carrier_final_gate", 8'h00, c_fin);
    chk8("peaking_final_gate", 8'h00, p_fin);
    rd_chk(5'h08, 8'h00);
    chk8("carrier_driver_gate", 8'h00, c_drv);
    @(posedge clock);
    tx_enable <= 1'b1;
    @(posedge clock);
    #1;
    chk8("carrier_final_gate", 8'hEF, c_fin);
    $display("test tx_switch done");
    do_reset(1'b1);
    rd_chk(5'h01, 8'h28);
    rd_chk(5'h06, 8'h80);
    chk1("override_unlock_state", 1'b0, unl);
    do_reset(1'b0);
    rd_chk(5'h04, 8'h20);
    $display("test reload done");
    report_and_stop();
  end
endmodule : bias_setting_override_bank_test
